// ---- hdl/rrs_defs.vh ----
// Opcode patterns, field positions and timing constants for the return/rotate/sleep decoder
`ifndef RRS_DEFS_VH
`define RRS_DEFS_VH
`define RRS_OP_W 14
`define RRS_RETURN_OP 14'h0008
`define RRS_SLEEP_OP 14'h0063
`define RRS_RET_LIT_HI 4'hD
`define RRS_ROT_LEFT_HI 6'h0D
`define RRS_ROT_RIGHT_HI 6'h0C
`define RRS_DEST_BIT 7
`define RRS_QUARTERS 4
`define RRS_STATUS_RST 8'h18
`define RRS_STAT_C 0
`define RRS_STAT_PWR_DOWN 3
`define RRS_STAT_WDOG_EXP 4
`define RRS_PRESCALE_MAX 8'hFF
`define RRS_ADDR_CTRL 12'h000
`define RRS_ADDR_INSTR 12'h004
`define RRS_ADDR_ACC 12'h008
`define RRS_ADDR_FILE 12'h00C
`define RRS_ADDR_STATUS 12'h010
`define RRS_ADDR_STACK 12'h014
`define RRS_ADDR_PC 12'h018
`define RRS_ADDR_WATCHDOG 12'h01C
`endif

// ---- hdl/rrs_qdiv.v ----
// Quarter-cycle divider producing one-cycle enables for each instruction cycle
`include "rrs_defs.vh"
module rrs_qdiv #(
    parameter QUARTERS = `RRS_QUARTERS
) (
    input wire pclk, // Core clock
    input wire presetn, // Async reset, active low
    input wire run, // Clock runs while high
    output reg q4_pulse // One cycle at the last quarter
);
    reg [3:0] q_ff;
    // Quarter counter stops while halted so no instruction slot advances
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= 4'h0;
            q4_pulse <= 1'b0;
        end else if (run) begin
            q4_pulse <= (q_ff == QUARTERS - 2);
            q_ff <= (q_ff == QUARTERS - 1) ? 4'h0 : q_ff + 4'h1;
        end else begin
            q4_pulse <= 1'b0;
        end
    end
endmodule // rrs_qdiv

// ---- hdl/rrs_core.v ----
// Execution unit for return, return-with-literal, rotates and sleep, with APB access
//
// Our own choices: the placing of the registers and register access over APB.
`include "rrs_defs.vh"
module rrs_core (
    input wire pclk, // APB clock, 25 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready, always high
    output wire pslverr, // APB error on unmapped address
    input wire wake_up, // Wake-up request from outside
    output wire osc_running, // Low while halted in sleep
    output wire instr_done // Pulse when an instruction retires
);
    // Register map, one aligned 32-bit word each, narrow fields in the low bits:
    //   0x00 control: bit 0 issue (self-clearing), bit 1 busy, bit 2 sleeping (both read-only)
    //   0x04 opcode under test, 14 bits
    //   0x08 accumulator, 8 bits
    //   0x0C the single modelled file register, 8 bits
    //   0x10 status: carry bit 0, power-down bit 3, watchdog-expiry bit 4 (both active low)
    //   0x14 stack head, 13 bits, stands in for the top of the call stack
    //   0x18 program counter, 13 bits
    //   0x1C watchdog: counter in bits 7:0, prescaler in bits 15:8, read-only
    // Writes while an instruction is in flight are dropped, so operands cannot move under it
    reg [13:0] instr_ff;
    reg issue_ff;
    reg [7:0] acc_ff;
    reg [7:0] file_ff;
    reg [7:0] status_ff;
    reg [12:0] stack_head_ff;
    reg [12:0] pc_ff;
    reg [7:0] watchdog_counter_ff;
    reg [7:0] prescaler_ff;
    reg sleeping_ff;
    reg idle_slot_ff;
    reg busy_ff;
    reg done_ff;
    reg wake_meta_ff;
    reg wake_sync_ff;
    wire q4_pulse;
    wire wr = psel && penable && pwrite;
    reg mapped;

    // Instruction-cycle timing; the divider freezes while asleep, standing in for the halted clock
    rrs_qdiv #(.QUARTERS(`RRS_QUARTERS)) u_qdiv (
        .pclk(pclk),
        .presetn(presetn),
        .run(!sleeping_ff),
        .q4_pulse(q4_pulse)
    );

    // Decode of the held opcode
    wire is_sleep = (instr_ff == `RRS_SLEEP_OP);
    wire is_return = (instr_ff == `RRS_RETURN_OP);
    wire is_ret_lit = (instr_ff[13:10] == `RRS_RET_LIT_HI);
    // The two rotates share their top five bits and differ only in bit 8
    wire is_rot_left = (instr_ff[13:8] == `RRS_ROT_LEFT_HI);
    wire is_rot_right = (instr_ff[13:8] == `RRS_ROT_RIGHT_HI);
    wire dest_file = instr_ff[`RRS_DEST_BIT];
    wire carry = status_ff[`RRS_STAT_C];
    wire rot_carry = is_rot_left ? file_ff[7] : file_ff[0];
    wire [7:0] rot_left;
    wire [7:0] rot_right;
    genvar gi;

    // Per-bit rotate network: each bit takes its neighbour, the end bit takes the old carry
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_rot
            if (gi == 0) begin : g_left_end
                assign rot_left[gi] = carry;
            end else begin : g_left_mid
                assign rot_left[gi] = file_ff[gi - 1];
            end
            if (gi == 7) begin : g_right_end
                assign rot_right[gi] = carry;
            end else begin : g_right_mid
                assign rot_right[gi] = file_ff[gi + 1];
            end
        end
    endgenerate

    // Zero wait states; the error flag is judged only in the access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign osc_running = !sleeping_ff;
    assign instr_done = done_ff;

    // Wake request comes from a pin; two flops settle it before the sleep logic sees it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
        end else begin
            wake_meta_ff <= wake_up;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    // Address decode; unmapped addresses read zero and flag an error
    always @* begin
        case (paddr)
            `RRS_ADDR_CTRL, `RRS_ADDR_INSTR, `RRS_ADDR_ACC, `RRS_ADDR_FILE,
            `RRS_ADDR_STATUS, `RRS_ADDR_STACK, `RRS_ADDR_PC, `RRS_ADDR_WATCHDOG: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux; a register so data leaves from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `RRS_ADDR_CTRL: prdata <= {29'h0, sleeping_ff, busy_ff, issue_ff};
                `RRS_ADDR_INSTR: prdata <= {18'h0, instr_ff};
                `RRS_ADDR_ACC: prdata <= {24'h0, acc_ff};
                `RRS_ADDR_FILE: prdata <= {24'h0, file_ff};
                `RRS_ADDR_STATUS: prdata <= {24'h0, status_ff};
                `RRS_ADDR_STACK: prdata <= {19'h0, stack_head_ff};
                `RRS_ADDR_PC: prdata <= {19'h0, pc_ff};
                `RRS_ADDR_WATCHDOG: prdata <= {16'h0, prescaler_ff, watchdog_counter_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Execution at the end of each instruction cycle; software writes only while idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_ff <= 14'h0000;
            issue_ff <= 1'b0;
            acc_ff <= 8'h00;
            file_ff <= 8'h00;
            status_ff <= `RRS_STATUS_RST;
            stack_head_ff <= 13'h0000;
            pc_ff <= 13'h0000;
            watchdog_counter_ff <= 8'h00;
            prescaler_ff <= 8'h00;
            sleeping_ff <= 1'b0;
            idle_slot_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            // Watchdog keeps counting while awake; no timeout is modelled for it
            if (!sleeping_ff) begin
                prescaler_ff <= prescaler_ff + 8'h01;
                if (prescaler_ff == `RRS_PRESCALE_MAX)
                    watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
            end
            // Only the settled copy of the pin may wake the core
            if (sleeping_ff && wake_sync_ff)
                sleeping_ff <= 1'b0;
            if (wr && !busy_ff) begin
                case (paddr)
                    `RRS_ADDR_CTRL: issue_ff <= pwdata[0];
                    `RRS_ADDR_INSTR: instr_ff <= pwdata[13:0];
                    `RRS_ADDR_ACC: acc_ff <= pwdata[7:0];
                    `RRS_ADDR_FILE: file_ff <= pwdata[7:0];
                    `RRS_ADDR_STATUS: status_ff <= pwdata[7:0];
                    `RRS_ADDR_STACK: stack_head_ff <= pwdata[12:0];
                    `RRS_ADDR_PC: pc_ff <= pwdata[12:0];
                    // Watchdog word is read-only; a write to it is accepted and ignored
                    default: ;
                endcase
            end
            // Issue is only taken while awake; a request made asleep waits for the wake
            if (issue_ff && !busy_ff && !sleeping_ff) begin
                busy_ff <= 1'b1;
                issue_ff <= 1'b0;
            end
            if (busy_ff && q4_pulse) begin
                if (idle_slot_ff) begin
                    // Second cycle of a branch does nothing
                    idle_slot_ff <= 1'b0;
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    // Default step; branches override it, unknown opcodes just retire
                    pc_ff <= pc_ff + 13'h0001;
                    // Sleep changes flags, watchdog and clock gate at one edge, never half of them
                    if (is_sleep) begin
                        status_ff[`RRS_STAT_PWR_DOWN] <= 1'b0;
                        status_ff[`RRS_STAT_WDOG_EXP] <= 1'b1;
                        watchdog_counter_ff <= 8'h00;
                        prescaler_ff <= 8'h00;
                        sleeping_ff <= 1'b1;
                    end else if (is_return) begin
                        // Pop now; busy stays high so the next slot is spent idle
                        pc_ff <= stack_head_ff;
                        idle_slot_ff <= 1'b1;
                        busy_ff <= 1'b1;
                        done_ff <= 1'b0;
                    end else if (is_ret_lit) begin
                        acc_ff <= instr_ff[7:0];
                        pc_ff <= stack_head_ff;
                        idle_slot_ff <= 1'b1;
                        busy_ff <= 1'b1;
                        done_ff <= 1'b0;
                    end else if (is_rot_left || is_rot_right) begin
                        // Carry takes the bit that is rotated out of the register
                        status_ff[`RRS_STAT_C] <= rot_carry;
                        if (dest_file)
                            file_ff <= is_rot_left ? rot_left : rot_right;
                        else
                            acc_ff <= is_rot_left ? rot_left : rot_right;
                    end
                end
            end
        end
    end
endmodule // rrs_core

// ---- tb/rrs_core_assertions.sv ----
// Port checker for the return/rotate/sleep core
module rrs_chk (
    input logic pclk, // Clock
    input logic presetn, // Reset, active low
    input logic psel, // Select
    input logic penable, // Enable
    input logic [11:0] paddr, // Address
    input logic [31:0] prdata, // Read data
    input logic pready, // Ready
    input logic pslverr, // Error
    input logic wake_up, // Wake request
    input logic osc_running, // Oscillator on
    input logic instr_done // Retire pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase of a transfer; the error flag is only judged there
    sequence s_acc;
        psel && penable;
    endsequence
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_unmapped: assert property (s_acc ##0 (paddr > 12'h01C) |-> pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (s_acc ##0 (paddr <= 12'h01C && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("rdata moved");
    a_done_pulse: assert property (instr_done |=> !instr_done) else $error("long retire pulse");
    a_sleep_quiet: assert property ((!osc_running)[*4] |-> !instr_done)
        else $error("retire while halted");
    a_wake_resume: assert property (!osc_running && wake_up |-> ##[1:4] osc_running)
        else $error("no wake");
endmodule // rrs_chk

bind rrs_core rrs_chk rrs_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_up(wake_up),
    .osc_running(osc_running), .instr_done(instr_done));

// ---- tb/tb_top.sv ----
// Self-checking bench for the return/rotate/sleep core
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake_up = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q, st, x = 32'h0000_0058;
    wire [31:0] prdata;
    wire pready, pslverr, osc_running, instr_done;
    int error_cnt = 0, checks = 0, acc, fil, pc, c, r, nc, k, n;
    rrs_core rrs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_up(wake_up), .osc_running(osc_running), .instr_done(instr_done));
    // 25 MHz clock
    initial begin
        forever #20 pclk = ~pclk;
    end
    // Xorshift source, fixed start
    function logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One transfer; an edge passes after release so back-to-back calls never collide
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Issue one opcode and wait, bounded, for it to retire
    task run(input logic [13:0] op);
        apb(1, 12'h004, {18'h0, op});
        apb(1, 12'h000, 32'h0000_0001);
        for (n = 0; instr_done !== 1'b1 && n < 40; n++) @(posedge pclk);
        chk({31'h0, n < 40}, 32'h1);
    endtask
    task summarize;
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        #400000;
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h010, 0);
        chk(q, 32'h18);
        chk({31'h0, err}, 32'h0);
        apb(0, 12'h020, 0);
        chk({31'h0, err}, 32'h1);
        // Both rotates, both destinations, both carry values, random data
        for (int i = 0; i < 16; i++) begin
            acc = rnd() & 255;
            fil = rnd() & 255;
            k = rnd();
            apb(1, 12'h008, acc);
            apb(1, 12'h00C, fil);
            apb(1, 12'h010, 32'h18 | i[2]);
            apb(0, 12'h010, 0);
            st = q;
            c = st[0];
            r = i[1] ? (c << 7 | fil >> 1) : ((fil << 1) & 255 | c);
            nc = i[1] ? fil & 1 : fil >> 7;
            run({5'h06, ~i[1], i[0], k[6:0]});
            apb(0, 12'h008, 0);
            chk(q, i[0] ? acc : r);
            apb(0, 12'h00C, 0);
            chk(q, i[0] ? r : fil);
            apb(0, 12'h010, 0);
            chk(q, st & 32'hFFFF_FFFE | nc);
        end
        // Literal return, then plain return
        for (int i = 0; i < 2; i++) begin
            k = rnd() & 255;
            pc = rnd() & 255;
            apb(1, 12'h014, pc);
            apb(0, 12'h010, 0);
            st = q;
            run(i ? 14'h0008 : {6'h34, k[7:0]});
            apb(0, 12'h018, 0);
            chk(q, pc);
            apb(0, 12'h010, 0);
            chk(q, st);
            apb(0, 12'h008, 0);
            chk(q, i ? acc : k);
            if (i == 0) acc = k;
        end
        // Near miss of the sleep pattern must not halt
        run(14'h0073);
        chk({31'h0, osc_running}, 32'h1);
        apb(0, 12'h010, 0);
        st = q;
        run(14'h0063);
        apb(0, 12'h010, 0);
        chk(q, st & 32'hFFFF_FFF7 | 32'h10);
        apb(0, 12'h01C, 0);
        chk(q, 0);
        apb(0, 12'h000, 0);
        chk(q & 32'h4, 32'h4);
        chk({31'h0, osc_running}, 32'h0);
        wake_up <= 1'b1;
        @(posedge pclk);
        wake_up <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'h0, osc_running}, 32'h1);
        summarize;
    end
endmodule // tb_top
